// ### hdl/pin_function_multiplexer.sv
// top of the pin function multiplexer: apb registers, port 0 cells, port 1 debug/trace
// assumes pins and peripherals synchronous to pclk; pads resolve oe_n themselves
`include "pinmux_consts.svh"
`timescale 1ns/1ps

// Summary of operation
// - reset low puts every port and peripheral default; fetch begins at zero
// - returned test clock low at the first edge after reset release selects debug port on port1 26 to 31
// - debug mode drives tdo, takes tdi tck tms trst, returned clock bidirectional
// - trace mode outputs pipeline status 2, trace clock; takes external trigger
// - each pin connects only its selected function, all others cut off
// - converter input always sees the pin level whatever is selected
// - converter result valid only when the analog function is selected
// - enabled peripheral without a routed pin behaves undefined, no guarantee
// - low select register read/write at 0xE002C000, resets to zero
// - high select register read/write at 0xE002C004, resets to zero
// - debug select register read/write at 0xE002C014, reset set by straps
// - reset values cover used bits only; reserved bits unspecified
// - direction bit acts only for gpio; other functions set direction themselves
module pin_function_multiplexer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic core_reset_n,
    output logic [31:0] boot_address,
    output logic debug_port_active,
    output logic trace_port_active,
    input wire logic [31:0] p0_pin_in,
    output logic [31:0] p0_pin_out,
    output logic [31:0] p0_pin_oe_n,
    input wire logic [15:0] p1_pin_in,
    output logic [15:0] p1_pin_out,
    output logic [15:0] p1_pin_oe_n,
    input wire logic [31:0] port0_direction_control,
    input wire logic [31:0] gpio0_out,
    output logic [31:0] gpio0_in,
    input wire logic [15:0] port1_direction_control,
    input wire logic [15:0] gpio1_out,
    output logic [15:0] gpio1_in,
    input wire logic [95:0] p0_func_out,
    input wire logic [95:0] p0_func_oe,
    output logic [95:0] p0_func_in,
    output logic [31:0] adc_level,
    output logic [31:0] adc_valid,
    input wire logic jtag_tdo,
    output logic jtag_tdi,
    output logic jtag_tck,
    output logic jtag_tms,
    output logic jtag_trst_n,
    input wire logic returned_test_clock_out,
    input wire logic returned_test_clock_oe,
    output logic returned_test_clock_in,
    input wire logic [6:0] trace_status_out,
    input wire logic pipeline_status_bit2,
    input wire logic trace_clock_out,
    output logic external_trigger_in
);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    sel_if sel ();

    sel_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .sel(sel.regs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // strap capture and core release

    pinmux_pkg::ctl_state_t c_q, c_d;

    // straps are read on the first edge after release, never inside the reset
    always_comb begin
        c_d = c_q;
        if (!c_q.strap_done) begin
            c_d.strap_done = 1'b1;
            c_d.core_run = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q.strap_done <= 1'b0;
            c_q.core_run <= 1'b0;
        end else begin
            c_q <= c_d;
        end
    end

    assign sel.strap_load = !c_q.strap_done;
    assign sel.strap_debug = !p1_pin_in[`P1_RETURNED_TEST_CLOCK];
    assign sel.strap_trace = !p1_pin_in[`P1_TRACE_STRAP];

    // core held until straps are in, then fetches from the fixed vector
    assign core_reset_n = c_q.core_run;
    assign boot_address = `BOOT_ADDR;
    assign debug_port_active = sel.debug_en;
    assign trace_port_active = sel.trace_en;

    ////////////////////////////////////////////////////////////////////////////
    // port 0

    // two bits per pin, low register for pins 0..15, high for 16..31
    function automatic logic [1:0] field_of(
        input logic [31:0] low,
        input logic [31:0] high,
        input int pin
    );
        logic [31:0] word;
        int idx;
        word = (pin < `PINS_PER_REG) ? low : high;
        idx = (pin % `PINS_PER_REG) * `FIELD_W;
        field_of = word[idx +: `FIELD_W];
    endfunction

    localparam logic [31:0] ANALOG_AT3 = `ANALOG_AT3_MASK;

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_p0
            pin_cell u_cell (
                .sel(field_of(sel.sel_low, sel.sel_high, g)),
                .analog_at3(ANALOG_AT3[g]),
                .gpio_out(gpio0_out[g]),
                .gpio_dir(port0_direction_control[g]),
                .gpio_in(gpio0_in[g]),
                .alt_out(p0_func_out[g*3 +: 3]),
                .alt_oe(p0_func_oe[g*3 +: 3]),
                .alt_in(p0_func_in[g*3 +: 3]),
                .pin_in(p0_pin_in[g]),
                .pin_out(p0_pin_out[g]),
                .pin_oe_n(p0_pin_oe_n[g]),
                .adc_level(adc_level[g]),
                .adc_valid(adc_valid[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // port 1: gpio unless debug (bits 10..15) or trace (bits 0..9) take over

    logic [15:0] p1_debug_own;
    logic [15:0] p1_trace_own;

    generate
        for (g = 0; g < 16; g++) begin : g_p1_own
            assign p1_debug_own[g] = sel.debug_en && (g >= `P1_RETURNED_TEST_CLOCK);
            assign p1_trace_own[g] = sel.trace_en && (g <= `P1_EXTTRIG);
        end
    endgenerate

    generate
        for (g = 0; g < 16; g++) begin : g_p1
            always_comb begin
                gpio1_in[g] = 1'b0;
                p1_pin_out[g] = gpio1_out[g];
                p1_pin_oe_n[g] = !port1_direction_control[g];
                if (p1_debug_own[g]) begin
                    // gpio cut off while the debug port owns the pin
                    p1_pin_out[g] = 1'b0;
                    p1_pin_oe_n[g] = 1'b1;
                    if (g == `P1_RETURNED_TEST_CLOCK) begin
                        p1_pin_out[g] = returned_test_clock_out;
                        p1_pin_oe_n[g] = !returned_test_clock_oe;
                    end
                    if (g == `P1_TDO) begin
                        p1_pin_out[g] = jtag_tdo;
                        p1_pin_oe_n[g] = 1'b0;
                    end
                end else if (p1_trace_own[g]) begin
                    p1_pin_out[g] = 1'b0;
                    p1_pin_oe_n[g] = 1'b0;
                    if (g < `P1_PIPELINE_STATUS_BIT2) begin
                        p1_pin_out[g] = trace_status_out[g % `P1_PIPELINE_STATUS_BIT2];
                    end
                    if (g == `P1_PIPELINE_STATUS_BIT2) begin
                        p1_pin_out[g] = pipeline_status_bit2;
                    end
                    if (g == `P1_TRACE_CLOCK_OUT) begin
                        p1_pin_out[g] = trace_clock_out;
                    end
                    if (g == `P1_EXTTRIG) begin
                        p1_pin_oe_n[g] = 1'b1;
                    end
                end else begin
                    gpio1_in[g] = p1_pin_in[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // inputs to the debug and trace logic

    // disconnected tap parks in reset with tms high, so it cannot wander
    always_comb begin
        jtag_tdi = 1'b0;
        jtag_tck = 1'b0;
        jtag_tms = 1'b1;
        jtag_trst_n = 1'b0;
        returned_test_clock_in = 1'b0;
        if (sel.debug_en) begin
            jtag_tdi = p1_pin_in[`P1_TDI];
            jtag_tck = p1_pin_in[`P1_TCK];
            jtag_tms = p1_pin_in[`P1_TMS];
            jtag_trst_n = p1_pin_in[`P1_TRST];
            returned_test_clock_in = p1_pin_in[`P1_RETURNED_TEST_CLOCK];
        end
    end

    // unrouted trigger reads low; its peripheral behaviour is then undefined
    assign external_trigger_in = sel.trace_en && p1_pin_in[`P1_EXTTRIG];

endmodule

// ### hdl/pinmux_consts.svh
// constants for the pin function multiplexer: addresses, reset values, bit positions
// assumes inclusion by every design file that decodes addresses or pins
`ifndef PINMUX_CONSTS_SVH
`define PINMUX_CONSTS_SVH

`define SEL_LOW_ADDR 32'hE002C000
`define SEL_HIGH_ADDR 32'hE002C004
`define SEL_DEBUG_ADDR 32'hE002C014
`define SEL_RESET 32'h00000000
`define DEBUG_EN_BIT 2
`define TRACE_EN_BIT 3
`define READ_ZERO 32'h00000000
`define BOOT_ADDR 32'h00000000

`define FIELD_W 2
`define PINS_PER_REG 16
`define SEL_GPIO 2'h0
`define SEL_ANALOG 2'h3
`define ANALOG_AT3_MASK 32'h0000B570

`define P1_BASE 16
`define P1_TRACE_STRAP 4
`define P1_PIPELINE_STATUS_BIT2 7
`define P1_TRACE_CLOCK_OUT 8
`define P1_EXTTRIG 9
`define P1_RETURNED_TEST_CLOCK 10
`define P1_TDO 11
`define P1_TDI 12
`define P1_TCK 13
`define P1_TMS 14
`define P1_TRST 15

`endif

// ### hdl/pinmux_pkg.sv
// types shared by the pin function multiplexer modules
// assumes nothing beyond the consts header
package pinmux_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_READY = 2'b10
    } apb_state_t;

    typedef struct packed {
        apb_state_t st;
        logic [31:0] sel_low;
        logic [31:0] sel_high;
        logic debug_en;
        logic trace_en;
        logic [31:0] rdata;
        logic err;
    } regs_state_t;

    typedef struct packed {
        logic strap_done;
        logic core_run;
    } ctl_state_t;

endpackage

// ### hdl/sel_if.sv
// select register contents and strap load between register file and pin logic
// assumes one clock domain, pclk
`timescale 1ns/1ps
interface sel_if;
    logic [31:0] sel_low;
    logic [31:0] sel_high;
    logic debug_en;
    logic trace_en;
    logic strap_load;
    logic strap_debug;
    logic strap_trace;

    modport regs (
        output sel_low,
        output sel_high,
        output debug_en,
        output trace_en,
        input strap_load,
        input strap_debug,
        input strap_trace
    );

    modport user (
        input sel_low,
        input sel_high,
        input debug_en,
        input trace_en,
        output strap_load,
        output strap_debug,
        output strap_trace
    );
endinterface

// ### hdl/sel_regs.sv
// apb slave holding the three function select registers
// assumes an apb master on pclk; zero wait states
`include "pinmux_consts.svh"
`timescale 1ns/1ps
module sel_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sel_if.regs sel
);

    pinmux_pkg::regs_state_t s_q, s_d;
    logic [2:0] hit;

    // one-hot hit vector: low, high, debug
    function automatic logic [2:0] decode(input logic [31:0] a);
        decode = {a == `SEL_DEBUG_ADDR, a == `SEL_HIGH_ADDR, a == `SEL_LOW_ADDR};
    endfunction

    // a call result cannot be bit-selected, so decode once into a vector
    assign hit = decode(paddr);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            pinmux_pkg::ST_IDLE: begin
                if (psel && !penable) begin
                    s_d.st = pinmux_pkg::ST_READY;
                    s_d.err = (hit == 3'h0);
                    s_d.rdata = `READ_ZERO;
                    if (hit[0]) begin
                        s_d.rdata = s_q.sel_low;
                    end
                    if (hit[1]) begin
                        s_d.rdata = s_q.sel_high;
                    end
                    // reserved bits read zero
                    if (hit[2]) begin
                        s_d.rdata[`DEBUG_EN_BIT] = s_q.debug_en;
                        s_d.rdata[`TRACE_EN_BIT] = s_q.trace_en;
                    end
                end
            end
            pinmux_pkg::ST_READY: begin
                if (psel && penable) begin
                    s_d.st = pinmux_pkg::ST_IDLE;
                    if (pwrite && hit[0]) begin
                        s_d.sel_low = pwdata;
                    end
                    if (pwrite && hit[1]) begin
                        s_d.sel_high = pwdata;
                    end
                    if (pwrite && hit[2]) begin
                        s_d.debug_en = pwdata[`DEBUG_EN_BIT];
                        s_d.trace_en = pwdata[`TRACE_EN_BIT];
                    end
                end else begin
                    s_d.st = pinmux_pkg::ST_IDLE;
                end
            end
        endcase
        // strap capture wins over a write in the same cycle
        if (sel.strap_load) begin
            s_d.debug_en = sel.strap_debug;
            s_d.trace_en = sel.strap_trace;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.st <= pinmux_pkg::ST_IDLE;
            s_q.sel_low <= `SEL_RESET;
            s_q.sel_high <= `SEL_RESET;
            s_q.debug_en <= 1'b0;
            s_q.trace_en <= 1'b0;
            s_q.rdata <= `READ_ZERO;
            s_q.err <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign pready = psel && penable && (s_q.st == pinmux_pkg::ST_READY);
    assign pslverr = pready && s_q.err;
    assign prdata = s_q.rdata;
    assign sel.sel_low = s_q.sel_low;
    assign sel.sel_high = s_q.sel_high;
    assign sel.debug_en = s_q.debug_en;
    assign sel.trace_en = s_q.trace_en;
endmodule

// ### hdl/pin_cell.sv
// one port 0 pin: gpio plus three alternate functions and an analog tap
// assumes peripherals give their own drive enables
`include "pinmux_consts.svh"
`timescale 1ns/1ps
module pin_cell (
    input wire logic [1:0] sel,
    input wire logic analog_at3,
    input wire logic gpio_out,
    input wire logic gpio_dir,
    output logic gpio_in,
    input wire logic [2:0] alt_out,
    input wire logic [2:0] alt_oe,
    output logic [2:0] alt_in,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic adc_level,
    output logic adc_valid
);

    always_comb begin
        gpio_in = 1'b0;
        alt_in = 3'h0;
        pin_out = 1'b0;
        pin_oe_n = 1'b1;
        if (sel == `SEL_GPIO) begin
            gpio_in = pin_in;
            pin_out = gpio_out;
            pin_oe_n = !gpio_dir;
        end else if (analog_at3 && sel == `SEL_ANALOG) begin
            // digital side stays off so the converter sees a quiet pad
            pin_oe_n = 1'b1;
        end else begin
            // unselected functions read zero and drive nothing
            alt_in[sel - 2'h1] = pin_in;
            pin_out = alt_out[sel - 2'h1];
            pin_oe_n = !alt_oe[sel - 2'h1];
        end
    end

    // converter tap is never cut off, but only valid with analog selected
    assign adc_level = pin_in;
    assign adc_valid = analog_at3 && (sel == `SEL_ANALOG);
endmodule

// ### bench/pinmux_props.sv
// checker on the pin function multiplexer top ports
// assumes one pclk domain; bound below onto the top module
`timescale 1ns/1ps
module pinmux_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_reset_n,
    input wire logic [31:0] boot_address,
    input wire logic debug_port_active,
    input wire logic trace_port_active,
    input wire logic [31:0] p0_pin_in,
    input wire logic [15:0] p1_pin_in,
    input wire logic [15:0] p1_pin_out,
    input wire logic [15:0] p1_pin_oe_n,
    input wire logic [31:0] adc_level,
    input wire logic [31:0] adc_valid,
    input wire logic jtag_tdo,
    input wire logic jtag_tck,
    input wire logic jtag_tms,
    input wire logic jtag_trst_n,
    input wire logic pipeline_status_bit2,
    input wire logic trace_clock_out,
    input wire logic external_trigger_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_boot;
        boot_address == 32'h00000000;
    endproperty
    a_boot: assert property (p_boot) else $error("boot address not zero");
    property p_core_hold;
        !$past(presetn) |-> !core_reset_n;
    endproperty
    a_core_hold: assert property (p_core_hold) else $error("core left reset early");
    property p_strap;
        $rose(core_reset_n) |-> debug_port_active == !$past(p1_pin_in[10]);
    endproperty
    a_strap: assert property (p_strap) else $error("debug strap not captured");
    property p_tdo;
        debug_port_active |-> p1_pin_out[11] == jtag_tdo && !p1_pin_oe_n[11];
    endproperty
    a_tdo: assert property (p_tdo) else $error("test data out not on pin");
    property p_jtag_in;
        debug_port_active |-> jtag_tck == p1_pin_in[13] && jtag_tms == p1_pin_in[14];
    endproperty
    a_jtag_in: assert property (p_jtag_in) else $error("test inputs not from pins");
    property p_jtag_off;
        !debug_port_active |-> !jtag_tck && jtag_tms && !jtag_trst_n;
    endproperty
    a_jtag_off: assert property (p_jtag_off) else $error("test inputs not cut off");
    property p_trace;
        trace_port_active |-> {p1_pin_out[8], p1_pin_out[7]} ==
            {trace_clock_out, pipeline_status_bit2};
    endproperty
    a_trace: assert property (p_trace) else $error("trace outputs not on pins");
    property p_trig;
        external_trigger_in == (trace_port_active && p1_pin_in[9]);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger input wrong");
    property p_adc;
        adc_level == p0_pin_in;
    endproperty
    a_adc: assert property (p_adc) else $error("converter does not see pin");
    property p_valid;
        (adc_valid & 32'hFFFF4A8F) == 32'h00000000;
    endproperty
    a_valid: assert property (p_valid) else $error("valid on non-analog pin");
endmodule

bind pin_function_multiplexer pinmux_props u_props (.pclk, .presetn, .pready, .pslverr,
    .core_reset_n, .boot_address, .debug_port_active, .trace_port_active, .p0_pin_in,
    .p1_pin_in, .p1_pin_out, .p1_pin_oe_n, .adc_level, .adc_valid, .jtag_tdo, .jtag_tck,
    .jtag_tms, .jtag_trst_n, .pipeline_status_bit2, .trace_clock_out, .external_trigger_in);

// ### bench/pin_world.sv
// pads and outside world around the multiplexer
// assumes the bench drives port 0 pins whenever the device lets go
`timescale 1ns/1ps
module pin_world (
    input wire logic [31:0] p0_pin_out,
    input wire logic [31:0] p0_pin_oe_n,
    input wire logic [15:0] p1_pin_out,
    input wire logic [15:0] p1_pin_oe_n,
    input wire logic [31:0] ext0_val,
    input wire logic [15:0] ext1_en,
    input wire logic [15:0] ext1_val,
    output logic [31:0] p0_pin_in,
    output logic [15:0] p1_pin_in
);
    // port 0 pads have no pull, so an outside level is always present
    assign p0_pin_in = (~p0_pin_oe_n & p0_pin_out) | (p0_pin_oe_n & ext0_val);
    // port 1 pull-ups keep the straps inactive unless pulled low
    assign p1_pin_in = (~p1_pin_oe_n & p1_pin_out) | (p1_pin_oe_n & ~ext1_en)
        | (p1_pin_oe_n & ext1_en & ext1_val);
endmodule

// ### bench/tb_top.sv
// self-checking bench for the pin function multiplexer
// assumes the checker is bound by its own file
`include "pinmux_consts.svh"
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_reset_n;
    logic [31:0] paddr, pwdata, prdata, boot_address, p0_pin_in, p0_pin_out, p0_pin_oe_n;
    logic [31:0] ext0_val, port0_direction_control, gpio0_out, gpio0_in, adc_level, adc_valid;
    logic [15:0] p1_pin_in, p1_pin_out, p1_pin_oe_n, ext1_en, ext1_val;
    logic [15:0] port1_direction_control, gpio1_out, gpio1_in;
    logic [95:0] p0_func_out, p0_func_oe, p0_func_in;
    logic debug_port_active, trace_port_active, jtag_tdo, jtag_tdi, jtag_tck, jtag_tms;
    logic jtag_trst_n, returned_test_clock_out, returned_test_clock_oe, returned_test_clock_in;
    logic pipeline_status_bit2, trace_clock_out, external_trigger_in;
    logic [6:0] trace_status_out;
    int num_errors, compares;
    pin_function_multiplexer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_reset_n, .boot_address, .debug_port_active,
        .trace_port_active, .p0_pin_in, .p0_pin_out, .p0_pin_oe_n, .p1_pin_in, .p1_pin_out,
        .p1_pin_oe_n, .port0_direction_control, .gpio0_out, .gpio0_in,
        .port1_direction_control, .gpio1_out, .gpio1_in, .p0_func_out, .p0_func_oe,
        .p0_func_in, .adc_level, .adc_valid, .jtag_tdo, .jtag_tdi, .jtag_tck, .jtag_tms,
        .jtag_trst_n, .returned_test_clock_out, .returned_test_clock_oe,
        .returned_test_clock_in, .trace_status_out, .pipeline_status_bit2, .trace_clock_out,
        .external_trigger_in);
    pin_world u_world (.p0_pin_out, .p0_pin_oe_n, .p1_pin_out, .p1_pin_oe_n, .ext0_val,
        .ext1_en, .ext1_val, .p0_pin_in, .p1_pin_in);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one idle edge after each transfer so no signal is set twice at one step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look mid-cycle: what stands here is what the next rising edge samples
        @(negedge pclk);
        for (int i = 0; i < 16 && pready !== 1'b1; i++) begin
            @(negedge pclk);
        end
        check(pready, 1'b1);
        if (!wr) check(prdata, exp);
        check(pslverr, exp_err);
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        @(negedge pclk);
        check(boot_address, 32'h00000000);
        check({core_reset_n, debug_port_active, trace_port_active}, 3'b110);
        @(posedge pclk);
        apb(1'b0, `SEL_LOW_ADDR, 0, 32'h00000000, 1'b0);
        apb(1'b0, `SEL_HIGH_ADDR, 0, 32'h00000000, 1'b0);
        apb(1'b0, `SEL_DEBUG_ADDR, 0, 32'h00000004, 1'b0);
        apb(1'b1, 32'hE002C008, 32'hFFFFFFFF, 0, 1'b1);
        apb(1'b0, 32'hE002C008, 0, 32'h00000000, 1'b1);
    endtask
    task automatic t_debug;
        ext1_en <= 16'h7000;
        ext1_val <= 16'h2000;
        jtag_tdo <= 1'b1;
        @(negedge pclk);
        check({jtag_tck, jtag_tms, returned_test_clock_in}, 3'b101);
        check({p1_pin_out[11], p1_pin_oe_n[11], gpio1_in[13]}, 3'b100);
        @(posedge pclk);
        apb(1'b1, `SEL_DEBUG_ADDR, 32'hFFFFFFF3, 0, 1'b0);
        apb(1'b0, `SEL_DEBUG_ADDR, 0, 32'h00000000, 1'b0);
        check({jtag_tck, jtag_tms}, 2'b01);
        apb(1'b1, `SEL_DEBUG_ADDR, 32'h00000008, 0, 1'b0);
        pipeline_status_bit2 <= 1'b1;
        ext1_en <= 16'h0200;
        ext1_val <= 16'h0200;
        @(negedge pclk);
        check({trace_port_active, external_trigger_in}, 2'b11);
        check({p1_pin_out[8:7], p1_pin_oe_n[8:7]}, 4'b0100);
        @(posedge pclk);
        apb(1'b1, `SEL_DEBUG_ADDR, 32'h00000000, 0, 1'b0);
    endtask
    task automatic t_select;
        @(negedge pclk);
        check({p0_pin_oe_n[4], p0_pin_out[4], adc_valid[4]}, 3'b010);
        @(posedge pclk);
        apb(1'b1, `SEL_LOW_ADDR, 32'h00000100, 0, 1'b0);
        check({p0_pin_oe_n[4], gpio0_in[4], p0_func_in[13:12]}, 4'b1001);
        p0_func_oe[12] <= 1'b1;
        @(negedge pclk);
        check({p0_pin_oe_n[4], p0_pin_out[4], adc_level[4]}, 3'b000);
        @(posedge pclk);
        apb(1'b1, `SEL_LOW_ADDR, 32'h00000303, 0, 1'b0);
        check({adc_valid[4], adc_valid[0]}, 2'b10);
        apb(1'b1, `SEL_HIGH_ADDR, 32'h00000002, 0, 1'b0);
        p0_func_oe[49] <= 1'b1;
        p0_func_out[49] <= 1'b1;
        @(negedge pclk);
        check({p0_pin_oe_n[16], p0_pin_out[16]}, 2'b01);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, `SEL_LOW_ADDR, 0, 32'h00000000, 1'b0);
        check(debug_port_active, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #20000;
        num_errors++;
        end_of_test;
    end
    initial begin
        {num_errors, compares} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {port0_direction_control, gpio0_out, ext0_val} = {32'h10, 32'h10, 32'hFFFFFFFF};
        {port1_direction_control, gpio1_out, p0_func_out, p0_func_oe} = '0;
        {jtag_tdo, returned_test_clock_out, returned_test_clock_oe, trace_status_out} = '0;
        {pipeline_status_bit2, trace_clock_out} = '0;
        // returned clock pin held low through reset to request the debug port
        ext1_en = 16'h0400;
        ext1_val = 16'h0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        ext1_en <= 16'h0000;
        t_reset;
        t_debug;
        t_select;
        end_of_test;
    end
endmodule
